// File: shared/pct_pkg.sv
// constants, register map and types of the pwm and carrier timer pair
package pct_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_MODE0   = 4'h0;
    localparam logic [3:0] OFS_PER0    = 4'h1;
    localparam logic [3:0] OFS_DUTY0   = 4'h2;
    localparam logic [3:0] OFS_MODE1   = 4'h3;
    localparam logic [3:0] OFS_PER1    = 4'h4;
    localparam logic [3:0] OFS_DUTY1   = 4'h5;
    localparam logic [3:0] OFS_CARRIER = 4'h6;
    localparam logic [3:0] OFS_STATUS  = 4'h7;
    localparam logic [3:0] OFS_MASK    = 4'h8;
    localparam logic [3:0] OFS_STATE   = 4'h9;
    // ------------------------------------------------------------
    // mode register fields
    // ------------------------------------------------------------
    localparam int MODE_EN_BIT   = 7;
    localparam int MODE_CKS_LSB  = 4;
    localparam int MODE_MD_LSB   = 2;
    localparam int MODE_OE_BIT   = 0;
    // carrier register fields
    localparam int CAR_NRZB_BIT  = 0;
    localparam int CAR_RMC_BIT   = 1;
    localparam int CAR_NRZ_BIT   = 2;
    // status bits: 0/1 match t0, 2/3 match t1
    localparam int ST_W          = 4;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] CMP_RST   = 8'h00;
    localparam logic [1:0] XFER_CNT  = 2'h3;
    localparam logic [2:0] RING_SAFE_CKS = 3'h5;
    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MD_INTERVAL,
        MD_PWM,
        MD_CARRIER,
        MD_RSVD
    } pct_mode_type;
endpackage

// File: hdl/pct_timer.sv
// one 8-bit compare timer with buffered duty compare
`timescale 1ns/100ps
module pct_timer (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] mode_i,
    input  wire logic [7:0] period_i,
    input  wire logic [7:0] duty_i,
    input  wire logic       duty_wr_i,
    input  wire logic [7:0] div_i,
    input  wire logic       ring_sel_i,
    input  wire logic       ring_tick_i,
    output logic            out_o,
    output logic            per_match_o,
    output logic            duty_match_o,
    output logic            bad_clk_o
);
    // ------------------------------------------------------------
    // count clock select
    // ------------------------------------------------------------
    logic [2:0]        cks;
    logic              en;
    pct_pkg::pct_mode_type md;
    logic              tick;
    logic [7:0]        cnt_r;
    logic [7:0]        act_duty_r;
    logic [1:0]        xfer_r;
    logic              pend_r;
    logic              lvl_r;
    logic              pm;
    logic              dm;

    assign cks  = mode_i[pct_pkg::MODE_CKS_LSB +: 3];
    assign en   = mode_i[pct_pkg::MODE_EN_BIT];
    assign md   = pct_pkg::pct_mode_type'(mode_i[pct_pkg::MODE_MD_LSB +: 2]);
    assign tick = ring_sel_i ? ring_tick_i : div_i[cks];
    assign bad_clk_o = ring_sel_i && (cks != pct_pkg::RING_SAFE_CKS);
    assign pm   = en && tick && (cnt_r == period_i);
    assign dm   = en && tick && (cnt_r == act_duty_r);

    // ------------------------------------------------------------
    // counter and output
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !en)
        begin
            cnt_r <= 8'h00;
            lvl_r <= 1'b0;
        end
        else if (tick)
        begin
            // clear on period, count up otherwise
            cnt_r <= (cnt_r == period_i) ? 8'h00 : cnt_r + 8'h01;
            // interval mode toggles on period, other modes rise there
            if (cnt_r == period_i)
                lvl_r <= (md == pct_pkg::MD_INTERVAL) ? ~lvl_r : 1'b1;
            else if (cnt_r == act_duty_r && md != pct_pkg::MD_INTERVAL)
                lvl_r <= 1'b0;
        end
    end

    // three count clocks to load duty
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            act_duty_r <= pct_pkg::CMP_RST;
            xfer_r     <= 2'h0;
            pend_r     <= 1'b0;
        end
        else if (duty_wr_i)
        begin
            xfer_r <= 2'h0;
            pend_r <= 1'b1;
        end
        else if (pend_r && tick && en)
        begin
            if (xfer_r == pct_pkg::XFER_CNT - 2'h1)
            begin
                act_duty_r <= duty_i;
                pend_r     <= 1'b0;
            end
            xfer_r <= xfer_r + 2'h1;
        end
    end

    assign out_o        = lvl_r & mode_i[pct_pkg::MODE_OE_BIT];
    assign per_match_o  = pm;
    assign duty_match_o = dm;
endmodule

// File: hdl/pct_top.sv
// two 8-bit compare timers with pwm and carrier modes
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Summary of operation
// - a pwm duty compare write takes effect after three count clocks.
// - buffered modulation bit copies into the gate bit; rewrites spaced two clocks.
// - carrier duty compare transfers after three or more count clocks.
// - ring clock source is guaranteed only for timer one with select 101.
// ----------------------------------------------------------------
module pct_top (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       ring_sel_i,
    input  wire logic       ring_tick_i,
    input  wire logic       companion_tick_i,
    output logic [7:0]      rdata_o,
    output logic            timer_zero_out_o,
    output logic            timer_one_out_o,
    output logic            irq_o
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_r [2];
    logic [7:0] per_r  [2];
    logic [7:0] duty_r [2];
    logic [7:0] div_tick;
    logic       nrzb_r;
    logic       nrz_r;
    logic       rmc_r;
    logic       cpy_r;
    logic [pct_pkg::ST_W-1:0] st_r;
    logic [pct_pkg::ST_W-1:0] mask_r;
    logic [7:0] rdata_r;
    logic       out0_r;
    logic       out1_r;
    logic       irq_r;

    logic [1:0] tout;
    logic [1:0] pm;
    logic [1:0] dm;
    logic [1:0] badc;
    logic [pct_pkg::ST_W-1:0] ev;
    logic [7:0] rd_mux;
    logic       carrier_md;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = wr_i && (a == ofs);
    endfunction

    // ------------------------------------------------------------
    // prescaler, shared by both timers
    // ------------------------------------------------------------
    logic [7:0] pre_r;
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            pre_r <= 8'h00;
        else
            pre_r <= pre_r + 8'h01;
    end
    // one-cycle tick per divided rate; bit 0 is undivided clock
    assign div_tick = {pre_r[6:0] == 7'h7f, pre_r[5:0] == 6'h3f, pre_r[4:0] == 5'h1f,
                    pre_r[3:0] == 4'hf, pre_r[2:0] == 3'h7, pre_r[1:0] == 2'h3,
                    pre_r[0], 1'b1};

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_tmr
            logic [3:0] mofs;
            logic [3:0] pofs;
            logic [3:0] dofs;
            assign mofs = (g == 0) ? pct_pkg::OFS_MODE0 : pct_pkg::OFS_MODE1;
            assign pofs = (g == 0) ? pct_pkg::OFS_PER0  : pct_pkg::OFS_PER1;
            assign dofs = (g == 0) ? pct_pkg::OFS_DUTY0 : pct_pkg::OFS_DUTY1;
            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                begin
                    mode_r[g] <= pct_pkg::MODE_RST;
                    per_r[g]  <= pct_pkg::CMP_RST;
                    duty_r[g] <= pct_pkg::CMP_RST;
                end
                else
                begin
                    if (hit(addr_i, mofs))
                        mode_r[g] <= mode_r[g][pct_pkg::MODE_EN_BIT]
                            ? {wdata_i[pct_pkg::MODE_EN_BIT], mode_r[g][6:0]} : wdata_i;
                    if (hit(addr_i, pofs) && !mode_r[g][pct_pkg::MODE_EN_BIT])
                        per_r[g] <= wdata_i;
                    if (hit(addr_i, dofs))
                        duty_r[g] <= wdata_i;
                end
            end
            pct_timer u_tmr (
                .clk_i        (clk_i),
                .reset_i      (reset_i),
                .mode_i       (mode_r[g]),
                .period_i     (per_r[g]),
                .duty_i       (duty_r[g]),
                .duty_wr_i    (hit(addr_i, dofs)),
                .div_i        (div_tick),
                .ring_sel_i   (ring_sel_i),
                .ring_tick_i  (ring_tick_i),
                .out_o        (tout[g]),
                .per_match_o  (pm[g]),
                .duty_match_o (dm[g]),
                .bad_clk_o    (badc[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // carrier gate
    // ------------------------------------------------------------
    assign carrier_md = mode_r[1][pct_pkg::MODE_MD_LSB +: 2] == 2'(pct_pkg::MD_CARRIER);
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            nrzb_r <= 1'b0;
            nrz_r  <= 1'b0;
            rmc_r  <= 1'b0;
            cpy_r  <= 1'b0;
        end
        else
        begin
            if (hit(addr_i, pct_pkg::OFS_CARRIER))
            begin
                nrzb_r <= wdata_i[pct_pkg::CAR_NRZB_BIT];
                rmc_r  <= wdata_i[pct_pkg::CAR_RMC_BIT];
            end
            // copy on companion tick, two clocks after write at earliest
            cpy_r <= hit(addr_i, pct_pkg::OFS_CARRIER);
            if (companion_tick_i && !cpy_r)
                nrz_r <= nrzb_r;
        end
    end

    // ------------------------------------------------------------
    // interrupts and outputs
    // ------------------------------------------------------------
    assign ev = {dm[1], pm[1], dm[0], pm[0]};
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_r   <= '0;
            mask_r <= '0;
        end
        else
        begin
            // set wins over write-one clear
            st_r <= (st_r & ~(hit(addr_i, pct_pkg::OFS_STATUS)
                     ? wdata_i[pct_pkg::ST_W-1:0] : '0)) | ev;
            if (hit(addr_i, pct_pkg::OFS_MASK))
                mask_r <= wdata_i[pct_pkg::ST_W-1:0];
        end
    end

    always_comb
    begin
        case (addr_i)
            pct_pkg::OFS_MODE0:   rd_mux = mode_r[0];
            pct_pkg::OFS_PER0:    rd_mux = per_r[0];
            pct_pkg::OFS_DUTY0:   rd_mux = duty_r[0];
            pct_pkg::OFS_MODE1:   rd_mux = mode_r[1];
            pct_pkg::OFS_PER1:    rd_mux = per_r[1];
            pct_pkg::OFS_DUTY1:   rd_mux = duty_r[1];
            pct_pkg::OFS_CARRIER: rd_mux = {5'h00, nrz_r, rmc_r, nrzb_r};
            pct_pkg::OFS_STATUS:  rd_mux = {4'h0, st_r};
            pct_pkg::OFS_MASK:    rd_mux = {4'h0, mask_r};
            // timer zero never safe on ring
            pct_pkg::OFS_STATE:   rd_mux = {4'h0, badc[1], badc[0] | ring_sel_i, tout};
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_r <= 8'h00;
            out0_r  <= 1'b0;
            out1_r  <= 1'b0;
            irq_r   <= 1'b0;
        end
        else
        begin
            rdata_r <= rd_i ? rd_mux : 8'h00;
            out0_r  <= tout[0];
            // carrier gated by modulation bit, idle level from level control
            out1_r  <= carrier_md ? (nrz_r ? tout[1] : rmc_r) : tout[1];
            irq_r   <= |(st_r & mask_r);
        end
    end

    assign rdata_o          = rdata_r;
    assign timer_zero_out_o = out0_r;
    assign timer_one_out_o  = out1_r;
    assign irq_o            = irq_r;
endmodule

// File: testbench/pct_top_asserts.sv
// assertions on register readback and interrupt level of the timer pair
`timescale 1ns/100ps
module pct_top_asserts (
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       irq_o
);
    // ------------------------------------------------------------
    // shadow registers
    // ------------------------------------------------------------
    logic [7:0] mode_r;
    logic [7:0] per_r;
    logic [3:0] mask_r;
    logic [1:0] car_r;
    wire        wr_mode  = wr_i && addr_i == pct_pkg::OFS_MODE0;
    wire        wr_per   = wr_i && addr_i == pct_pkg::OFS_PER0;
    wire        wr_car   = wr_i && addr_i == pct_pkg::OFS_CARRIER;
    wire        rd_mode  = rd_i && addr_i == pct_pkg::OFS_MODE0;
    wire        rd_per   = rd_i && addr_i == pct_pkg::OFS_PER0;
    wire        rd_car   = rd_i && addr_i == pct_pkg::OFS_CARRIER;
    wire        mask_off = mask_r == 4'h0;
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            mode_r <= 8'h00;
            per_r  <= 8'h00;
            mask_r <= 4'h0;
            car_r  <= 2'h0;
        end
        else
        begin
            // only the enable bit passes while counting
            if (wr_mode)
                mode_r <= mode_r[7] ? {wdata_i[7], mode_r[6:0]} : wdata_i;
            if (wr_per && !mode_r[7])
                per_r <= wdata_i;
            if (wr_i && addr_i == pct_pkg::OFS_MASK)
                mask_r <= wdata_i[3:0];
            if (wr_car)
                car_r <= wdata_i[1:0];
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // bit 1 is unused, so it is left out of the match
    mode_guard_a: assert property (
        $past(rd_mode) |-> (rdata_o & 8'hfd) == ($past(mode_r) & 8'hfd))
        else $error("mode readback differs from accepted write");
    period_hold_a: assert property (
        $past(rd_per) |-> rdata_o == $past(per_r))
        else $error("period changed while counting");
    level_keep_a: assert property (
        $past(rd_car) |-> rdata_o[1:0] == $past(car_r))
        else $error("carrier level or buffered bit lost");
    irq_masked_a: assert property (
        $past(mask_off) && $past(mask_off, 2) |-> !irq_o)
        else $error("interrupt high with all sources masked");
    read_idle_a: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside the read answer cycle");
endmodule
bind pct_top pct_top_asserts u_chk (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .irq_o);

// File: testbench/pct_partner.sv
// companion event counter and divided ring clock at the far side
`timescale 1ns/100ps
module pct_partner #(
    parameter int COMP_DIV = 16,
    parameter int RING_DIV = 4
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    output logic      companion_tick_o = 1'b0,
    output logic      ring_tick_o = 1'b0
);
    int cnt_r = 0;
    // companion far slower than count clock
    always @(posedge clk_i)
    begin
        cnt_r            <= reset_i ? 0 : cnt_r + 1;
        companion_tick_o <= !reset_i && (cnt_r % COMP_DIV == COMP_DIV - 1);
        ring_tick_o      <= !reset_i && (cnt_r % RING_DIV == 0);
    end
endmodule

// File: testbench/tb_top.sv
// self-checking bench of the pwm and carrier timer pair
`timescale 1ns/100ps
module tb_top;
    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr_s = 1'b0;
    logic       rd_s = 1'b0;
    logic       ring_sel = 1'b0;
    logic       ring_tick;
    logic       comp_tick;
    logic [7:0] rdata;
    logic       t0;
    logic       t1;
    logic       irq;
    logic [7:0] n;
    logic [7:0] m;
    int         miscompares = 0;
    int         total_checks = 0;
    int         cyc = 0;
    int         hi;
    int         per;
    always #50 clk_i = ~clk_i;
    pct_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_s), .rd_i(rd_s), .ring_sel_i(ring_sel), .ring_tick_i(ring_tick),
        .companion_tick_i(comp_tick), .rdata_o(rdata), .timer_zero_out_o(t0),
        .timer_one_out_o(t1), .irq_o(irq));
    pct_partner far (.clk_i(clk_i), .reset_i(reset_i), .companion_tick_o(comp_tick),
        .ring_tick_o(ring_tick));
    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e)
        begin
            $display("wrong value %s expected %h seen %h", name, e, s);
            miscompares++;
        end
    endtask
    // the idle edge after each strobe keeps a strobe from being set twice at once
    // wr and rd_chk first wait for an edge, so a caller's #1 never moves the strobes
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk_i);
        wr_s <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] mk, input logic [7:0] e,
        input string name);
        @(posedge clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1;
        chk(name, e, rdata & mk);
        @(posedge clk_i);
    endtask
    task automatic pwm_meas(input logic sel);
        logic p;
        logic o;
        int   st;
        p   = 1'b1;
        st  = 0;
        hi  = 0;
        per = 0;
        while (st < 2 && cyc < 29000)
        begin
            @(posedge clk_i);
            #1;
            o = sel ? t1 : t0;
            if (o && !p)
                st++;
            if (st == 1)
                per++;
            if (st == 1 && o)
                hi++;
            p = o;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            miscompares++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(58494));
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 16; a++)
            rd_chk(4'(a), 8'hff, 8'h00, "reset value");
        $display("test reset done");
        n = 8'(8 + $urandom % 190);
        m = 8'($urandom % n);
        wr(pct_pkg::OFS_PER0, n);
        wr(pct_pkg::OFS_DUTY0, m);
        wr(pct_pkg::OFS_MODE0, 8'h85);
        wr(pct_pkg::OFS_MODE0, 8'hfa);
        wr(pct_pkg::OFS_PER0, 8'h03);
        rd_chk(pct_pkg::OFS_MODE0, 8'hfd, 8'h85, "mode0");
        rd_chk(pct_pkg::OFS_PER0, 8'hff, n, "period0");
        pwm_meas(1'b0);
        chk("pwm period", n + 8'h01, 8'(per));
        chk("pwm high", m + 8'h01, 8'(hi));
        m = 8'($urandom % n);
        wr(pct_pkg::OFS_DUTY0, m);
        repeat (4) @(posedge clk_i);
        pwm_meas(1'b0);
        chk("pwm reload", m + 8'h01, 8'(hi));
        $display("test pwm done");
        wr(pct_pkg::OFS_MASK, 8'h01);
        repeat (2) @(posedge clk_i);
        #1 chk("irq on", 8'h01, {7'h00, irq});
        wr(pct_pkg::OFS_MASK, 8'h00);
        repeat (2) @(posedge clk_i);
        #1 chk("irq masked", 8'h00, {7'h00, irq});
        wr(pct_pkg::OFS_MODE0, 8'h05);
        wr(pct_pkg::OFS_STATUS, 8'h0f);
        rd_chk(pct_pkg::OFS_STATUS, 8'hff, 8'h00, "status");
        wr(pct_pkg::OFS_MASK, 8'h01);
        repeat (2) @(posedge clk_i);
        #1 chk("irq cleared", 8'h00, {7'h00, irq});
        $display("test irq done");
        wr(pct_pkg::OFS_CARRIER, 8'h02);
        n = 8'(2 + $urandom % 254);
        wr(pct_pkg::OFS_PER1, n);
        wr(pct_pkg::OFS_DUTY1, 8'h01);
        wr(pct_pkg::OFS_MODE1, 8'h89);
        repeat (40) @(posedge clk_i);
        #1 chk("carrier level", 8'h01, {7'h00, t1});
        wr(pct_pkg::OFS_CARRIER, 8'h03);
        repeat (40) @(posedge clk_i);
        rd_chk(pct_pkg::OFS_CARRIER, 8'h07, 8'h07, "gate on");
        pwm_meas(1'b1);
        chk("carrier period", n + 8'h01, 8'(per));
        chk("carrier high", 8'h02, 8'(hi));
        m = 8'(1 + $urandom % (n - 8'h01));
        wr(pct_pkg::OFS_DUTY1, m);
        repeat (4) @(posedge clk_i);
        pwm_meas(1'b1);
        chk("carrier reload", m + 8'h01, 8'(hi));
        wr(pct_pkg::OFS_CARRIER, 8'h00);
        repeat (40) @(posedge clk_i);
        rd_chk(pct_pkg::OFS_CARRIER, 8'h07, 8'h00, "gate off");
        chk("gated out", 8'h00, {7'h00, t1});
        $display("test carrier done");
        wr(pct_pkg::OFS_MODE1, 8'h09);
        wr(pct_pkg::OFS_MODE0, 8'h55);
        ring_sel <= 1'b1;
        wr(pct_pkg::OFS_MODE1, 8'h59);
        wr(pct_pkg::OFS_DUTY1, 8'h01);
        wr(pct_pkg::OFS_MODE1, 8'hd9);
        rd_chk(pct_pkg::OFS_STATE, 8'h0c, 8'h04, "ring ok");
        wr(pct_pkg::OFS_MODE1, 8'h09);
        wr(pct_pkg::OFS_DUTY1, 8'h01);
        wr(pct_pkg::OFS_MODE1, 8'h89);
        rd_chk(pct_pkg::OFS_STATE, 8'h0c, 8'h0c, "ring bad");
        $display("test ring done");
        complete_run();
    end
endmodule
